// ==== pcrs_pkg.sv ====
// Package of constants and types for the program counter and return stack
package pcrs_pkg;

	// ------------------------------------------------------------
	// Register byte addresses on the bus
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_PCL = 8'h00;
	localparam logic [7:0] OFS_PC_HIGH_LATCH = 8'h04;
	localparam logic [7:0] OFS_PC_UPPER_LATCH = 8'h08;
	localparam logic [7:0] OFS_RETURN_STACK_POINTER = 8'h0C;
	localparam logic [7:0] OFS_TOP_OF_STACK_UPPER = 8'h10;
	localparam logic [7:0] OFS_TOP_OF_STACK_HIGH = 8'h14;
	localparam logic [7:0] OFS_TOP_OF_STACK_LOW = 8'h18;
	localparam logic [7:0] OFS_PCFULL = 8'h1C;

	// ------------------------------------------------------------
	// Widths, fields and reset values
	// ------------------------------------------------------------
	localparam int PC_W = 21;
	localparam int SP_W = 5;
	localparam int STK_DEPTH = 31;
	localparam logic [SP_W-1:0] SP_RST = 5'h00;
	localparam logic [PC_W-1:0] PC_RST = 21'h000000;
	localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
	localparam logic [PC_W-1:0] VEC_HIGH = 21'h000008;
	localparam logic [PC_W-1:0] VEC_LOW = 21'h000018;
	localparam int BIT_FULL = 7;
	localparam int BIT_UNF = 6;
	localparam int BIT_OVF = 5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Core command codes
	// ------------------------------------------------------------
	typedef enum logic [2:0]
	{
		CMD_NONE = 3'b000,
		CMD_JUMP = 3'b001,
		CMD_CALL = 3'b010,
		CMD_RET = 3'b011,
		CMD_IRQ_HI = 3'b100,
		CMD_IRQ_LO = 3'b101
	} pcrs_cmd_t;

	typedef struct packed
	{
		logic [PC_W-1:0] pc;
		logic [7:0] lath;
		logic [7:0] latu;
		logic [SP_W-1:0] sp;
		logic full;
		logic ovf;
		logic unf;
		logic awv;
		logic [7:0] awa;
		logic wv;
		logic [31:0] wd;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic arready;
	} pcrs_state_t;

endpackage

// ==== pcrs_top.sv ====
// Program counter with latch registers, return stack and AXI4-Lite slave
// Behaviour
// [RULE_01] 21-bit counter in low, high, upper bytes
// [RULE_02] Low byte direct; high byte via latch only
// [RULE_03] Upper byte updated via its latch only
// [RULE_04] Low byte write loads both latches into counter
// [RULE_05] Low byte read copies upper bytes into latches
// [RULE_06] Low byte bit zero always reads zero
// [RULE_07] Counter advances by two per instruction
// [RULE_08] Calls, jumps, branches load counter directly
// [RULE_09] Calls and interrupts push, 31 deep
// [RULE_10] Returns pop stack into counter
// [RULE_11] Calls and returns leave latches alone
// [RULE_12] Stack is 31 by 21, 5-bit pointer
// [RULE_13] Software reads and writes pointer and top
// [RULE_14] Push increments pointer then writes entry
// [RULE_15] Pop reads entry then decrements pointer
// [RULE_16] Reset clears pointer; zero has no storage
// [RULE_17] Status bits full, overflow, underflow
// [RULE_18] Top entry seen through three byte registers
// [RULE_19] Software masks interrupts while touching stack
// [RULE_20] Interrupt wake pushes counter and advances pointer
// [RULE_21] Interrupt loads high or low vector
// [RULE_22] Overflow blocks write; empty pop flags underflow
`timescale 1ns/100ps
module pcrs_top
#(
	parameter int DEPTH = pcrs_pkg::STK_DEPTH
)
(
	input wire logic MCLK,
	input wire logic RST,
	input wire logic STEP,
	input wire logic [2:0] CMD,
	input wire logic [20:0] TARGET,
	output logic [20:0] FETCH_ADDR,
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY
);

	pcrs_pkg::pcrs_state_t s_reg;
	pcrs_pkg::pcrs_state_t s_next;
	logic [20:0] stack_reg [1:DEPTH];
	logic [20:0] stack_next [1:DEPTH];
	logic [20:0] top_entry;
	logic do_wr;
	logic do_rd;
	logic [20:0] lat_pc;
	logic [20:0] ent;
	logic [4:0] sp_inc;

	// ------------------------------------------------------------
	// Top entry view
	// ------------------------------------------------------------
	always_comb
	begin
		top_entry = '0;
		for (int i = 1; i <= DEPTH; i++)
		begin
			if (s_reg.sp == 5'(i))
			begin
				top_entry = stack_reg[i]; // [RULE_18]
			end
		end
	end

	assign do_wr = s_reg.awv && s_reg.wv && !s_reg.bvalid;
	assign do_rd = ARVALID && s_reg.arready && !s_reg.rvalid;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		s_next = s_reg;
		stack_next = stack_reg;
		lat_pc = {s_reg.latu[4:0], s_reg.lath, 8'h00};
		ent = top_entry;
		sp_inc = s_reg.sp + 5'h01;
		s_next.arready = 1'b0;
		if (STEP)
		begin
			s_next.pc = s_reg.pc + pcrs_pkg::PC_STEP; // [RULE_07]
		end
		unique case (CMD)
			pcrs_pkg::CMD_JUMP:
			begin
				s_next.pc = TARGET; // [RULE_08]
			end
			pcrs_pkg::CMD_CALL, pcrs_pkg::CMD_IRQ_HI, pcrs_pkg::CMD_IRQ_LO:
			begin
				if (s_reg.sp >= 5'(DEPTH))
				begin
					s_next.ovf = 1'b1; // [RULE_22]
				end
				else
				begin
					s_next.sp = sp_inc; // [RULE_14] [RULE_09] [RULE_20]
					for (int i = 1; i <= DEPTH; i++)
					begin
						if (sp_inc == 5'(i))
						begin
							stack_next[i] = s_reg.pc + pcrs_pkg::PC_STEP; // [RULE_14]
						end
					end
					s_next.full = (sp_inc == 5'(DEPTH)); // [RULE_17]
				end
				if (CMD == pcrs_pkg::CMD_CALL)
				begin
					s_next.pc = TARGET; // [RULE_08] [RULE_11]
				end
				else if (CMD == pcrs_pkg::CMD_IRQ_HI)
				begin
					s_next.pc = pcrs_pkg::VEC_HIGH; // [RULE_21]
				end
				else
				begin
					s_next.pc = pcrs_pkg::VEC_LOW; // [RULE_21]
				end
			end
			pcrs_pkg::CMD_RET:
			begin
				if (s_reg.sp == pcrs_pkg::SP_RST)
				begin
					s_next.unf = 1'b1; // [RULE_22] [RULE_16]
					s_next.pc = pcrs_pkg::PC_RST;
				end
				else
				begin
					s_next.pc = top_entry; // [RULE_15] [RULE_10] [RULE_11]
					s_next.sp = s_reg.sp - 5'h01; // [RULE_15]
					s_next.full = 1'b0;
				end
			end
			default:
			begin
			end
		endcase
		// AXI write channel capture
		if (AWVALID && !s_reg.awv)
		begin
			s_next.awv = 1'b1;
			s_next.awa = AWADDR;
		end
		if (WVALID && !s_reg.wv)
		begin
			s_next.wv = 1'b1;
			s_next.wd = WDATA;
		end
		if (s_reg.bvalid && BREADY)
		begin
			s_next.bvalid = 1'b0;
		end
		if (do_wr)
		begin
			s_next.awv = 1'b0;
			s_next.wv = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = pcrs_pkg::RESP_OKAY;
			if (s_reg.wd[7:0] != 8'h00 || WSTRB == 4'h0 || WSTRB != 4'h0)
			begin
			end
			unique case ({s_reg.awa[7:2], 2'b00})
				pcrs_pkg::OFS_PCL:
				begin
					s_next.pc = {lat_pc[20:8], s_reg.wd[7:1], 1'b0}; // [RULE_04] [RULE_06]
				end
				pcrs_pkg::OFS_PC_HIGH_LATCH:
				begin
					s_next.lath = s_reg.wd[7:0]; // [RULE_02]
				end
				pcrs_pkg::OFS_PC_UPPER_LATCH:
				begin
					s_next.latu = {3'h0, s_reg.wd[4:0]}; // [RULE_03]
				end
				pcrs_pkg::OFS_RETURN_STACK_POINTER:
				begin
					s_next.sp = s_reg.wd[4:0]; // [RULE_13]
					s_next.full = (s_reg.wd[4:0] == 5'(DEPTH));
					s_next.ovf = s_reg.ovf & s_reg.wd[pcrs_pkg::BIT_OVF]; // write zero clears
					s_next.unf = s_reg.unf & s_reg.wd[pcrs_pkg::BIT_UNF];
				end
				pcrs_pkg::OFS_TOP_OF_STACK_UPPER, pcrs_pkg::OFS_TOP_OF_STACK_HIGH, pcrs_pkg::OFS_TOP_OF_STACK_LOW:
				begin
					if ({s_reg.awa[7:2], 2'b00} == pcrs_pkg::OFS_TOP_OF_STACK_UPPER)
					begin
						ent[20:16] = s_reg.wd[4:0];
					end
					else if ({s_reg.awa[7:2], 2'b00} == pcrs_pkg::OFS_TOP_OF_STACK_HIGH)
					begin
						ent[15:8] = s_reg.wd[7:0];
					end
					else
					begin
						ent[7:0] = s_reg.wd[7:0];
					end
					for (int i = 1; i <= DEPTH; i++)
					begin
						if (s_reg.sp == 5'(i))
						begin
							stack_next[i] = ent; // [RULE_13] [RULE_18]
						end
					end
				end
				default:
				begin
					s_next.bresp = pcrs_pkg::RESP_SLVERR;
				end
			endcase
		end
		// AXI read channel
		if (s_reg.rvalid && RREADY)
		begin
			s_next.rvalid = 1'b0;
		end
		if (ARVALID && !s_reg.arready && !s_reg.rvalid)
		begin
			s_next.arready = 1'b1;
		end
		if (do_rd)
		begin
			s_next.rvalid = 1'b1;
			s_next.rresp = pcrs_pkg::RESP_OKAY;
			s_next.rdata = 32'h00000000;
			unique case ({ARADDR[7:2], 2'b00})
				pcrs_pkg::OFS_PCL:
				begin
					s_next.rdata = {24'h000000, s_reg.pc[7:1], 1'b0}; // [RULE_06]
					s_next.lath = s_reg.pc[15:8]; // [RULE_05]
					s_next.latu = {3'h0, s_reg.pc[20:16]}; // [RULE_05]
				end
				pcrs_pkg::OFS_PC_HIGH_LATCH:
				begin
					s_next.rdata = {24'h000000, s_reg.lath};
				end
				pcrs_pkg::OFS_PC_UPPER_LATCH:
				begin
					s_next.rdata = {24'h000000, s_reg.latu};
				end
				pcrs_pkg::OFS_RETURN_STACK_POINTER:
				begin
					s_next.rdata = {24'h000000, s_reg.full, s_reg.unf, s_reg.ovf, s_reg.sp}; // [RULE_17]
				end
				pcrs_pkg::OFS_TOP_OF_STACK_UPPER:
				begin
					s_next.rdata = {27'h0000000, top_entry[20:16]}; // [RULE_18]
				end
				pcrs_pkg::OFS_TOP_OF_STACK_HIGH:
				begin
					s_next.rdata = {24'h000000, top_entry[15:8]};
				end
				pcrs_pkg::OFS_TOP_OF_STACK_LOW:
				begin
					s_next.rdata = {24'h000000, top_entry[7:0]};
				end
				pcrs_pkg::OFS_PCFULL:
				begin
					s_next.rdata = {11'h000, s_reg.pc};
				end
				default:
				begin
					s_next.rresp = pcrs_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			s_reg <= '0; // [RULE_16]
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	// Stack storage, entry 0 has none
	generate
		for (genvar g = 1; g <= DEPTH; g++)
		begin : g_stk
			always_ff @(posedge MCLK)
			begin
				stack_reg[g] <= stack_next[g]; // [RULE_12]
			end
		end
	endgenerate

	assign FETCH_ADDR = s_reg.pc; // [RULE_01]
	assign AWREADY = !s_reg.awv;
	assign WREADY = !s_reg.wv;
	assign BVALID = s_reg.bvalid;
	assign BRESP = s_reg.bresp;
	assign ARREADY = s_reg.arready;
	assign RVALID = s_reg.rvalid;
	assign RDATA = s_reg.rdata;
	assign RRESP = s_reg.rresp;

endmodule

// ==== pcrs_monitor.sv ====
// Checker of fetch address and bus timing
`timescale 1ns/100ps
module pcrs_monitor
(
	input wire logic MCLK,
	input wire logic RST,
	input wire logic STEP,
	input wire logic [2:0] CMD,
	input wire logic [20:0] TARGET,
	input wire logic [20:0] FETCH_ADDR,
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic WVALID,
	input wire logic WREADY,
	input wire logic BVALID,
	input wire logic BREADY,
	input wire logic [1:0] BRESP,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic RVALID,
	input wire logic RREADY,
	input wire logic [31:0] RDATA
);
	default clocking @(posedge MCLK);
	endclocking
	default disable iff (RST);
	// Counter checks run only while no write address is held or offered
	logic q;
	assign q = AWREADY && !AWVALID;
	sequence s_wr;
		!AWREADY && !WREADY ##1 BVALID;
	endsequence
	sequence s_rd;
		ARREADY ##1 RVALID;
	endsequence
	a_step_two: assert property (q && CMD == 3'h0 && STEP |=> FETCH_ADDR == $past(FETCH_ADDR) + 21'h000002)
		else $error("step");
	a_load_target: assert property (q && (CMD == 3'h1 || CMD == 3'h2) |=> FETCH_ADDR == $past(TARGET))
		else $error("load");
	a_vector_high: assert property (q && CMD == 3'h4 |=> FETCH_ADDR == 21'h000008)
		else $error("high vector");
	a_vector_low: assert property (q && CMD == 3'h5 |=> FETCH_ADDR == 21'h000018)
		else $error("low vector");
	a_write_walk: assert property (AWVALID && WVALID && AWREADY && WREADY |=> s_wr)
		else $error("write timing");
	a_bresp_held: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write response");
	a_read_walk: assert property ($rose(ARVALID) |=> s_rd)
		else $error("read timing");
	a_rdata_held: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
		else $error("read data");
	a_reset_clear: assert property (disable iff (1'b0) RST |=> FETCH_ADDR == 21'h0 && !BVALID && !RVALID)
		else $error("reset");
endmodule
bind pcrs_top pcrs_monitor pcrs_monitor_inst (.*);

// ==== pcrs_core_model.sv ====
// Core model issuing one request per clock edge
`timescale 1ns/100ps
module pcrs_core_model
(
	input wire logic clk,
	input wire logic bus_busy,
	output logic step = 1'b0,
	output logic [2:0] cmd = 3'h0,
	output logic [20:0] target = 21'h0
);
	task automatic issue(logic [2:0] c, logic [20:0] t, logic s);
		step <= s;
		cmd <= c[2] && bus_busy ? 3'h0 : c;
		target <= t;
		@(posedge clk);
	endtask
endmodule

// ==== pcrs_tb_top.sv ====
// Testbench for the program counter and return stack
`timescale 1ns/100ps
module pcrs_tb_top;
	logic MCLK, RST, STEP, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
	logic unf, ovf;
	logic [2:0] CMD;
	logic [20:0] TARGET, FETCH_ADDR, pc;
	logic [20:0] stk [32];
	logic [7:0] AWADDR, ARADDR, lh, lu;
	logic [4:0] sp;
	logic [31:0] WDATA, RDATA;
	logic [1:0] BRESP, RRESP;
	logic [33:0] qr [$];
	logic [1:0] qb [$];
	int mismatches, check_count;

	pcrs_top pcrs_top_inst (.MCLK, .RST, .STEP, .CMD, .TARGET, .FETCH_ADDR, .AWADDR, .AWVALID, .AWREADY, .WDATA,
		.WSTRB(4'hF), .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP,
		.RVALID, .RREADY);
	pcrs_core_model pcrs_core_model_inst (.clk(MCLK), .bus_busy(AWVALID | ARVALID), .step(STEP), .cmd(CMD),
		.target(TARGET));

	initial
	begin
		MCLK = 1'b0;
		forever #25 MCLK = ~MCLK;
	end

	task automatic conclude();
		$display("Checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic tmo();
		mismatches++;
		$display("[FAIL] %0t no answer", $time);
		conclude();
	endtask

	task automatic check(logic [33:0] s, e);
		check_count++;
		if (s !== e)
		begin
			mismatches++;
			$display("[FAIL] %0t got %h want %h", $time, s, e);
		end
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r = 2'h0);
		@(posedge MCLK);
		qb.push_back(r);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		repeat (40)
		begin
			@(posedge MCLK);
			if (AWREADY)
				AWVALID <= 1'b0;
			if (WREADY)
				WVALID <= 1'b0;
			if (BVALID && BREADY)
				break;
			BREADY <= BVALID;
		end
		BREADY <= 1'b0;
		if (!(BVALID && BREADY))
			tmo();
	endtask

	task automatic rd(logic [7:0] a, logic [31:0] e, logic [1:0] r = 2'h0);
		@(posedge MCLK);
		qr.push_back({r, e});
		ARADDR <= a;
		ARVALID <= 1'b1;
		repeat (40)
		begin
			@(posedge MCLK);
			if (ARREADY)
				ARVALID <= 1'b0;
			if (RVALID && RREADY)
				break;
			RREADY <= RVALID;
		end
		RREADY <= 1'b0;
		if (!(RVALID && RREADY))
			tmo();
	endtask

	// Core request plus expected counter and stack
	task automatic op(logic [2:0] c, logic [20:0] a = 21'h0, logic s = 1'b0);
		pcrs_core_model_inst.issue(c, a, s);
		if (c == 3'h1)
			pc = a;
		else if (c == 3'h3)
		begin
			pc = sp ? stk[sp] : 21'h0;
			unf |= !sp;
			sp -= 5'(sp != 0);
		end
		else if (c != 3'h0)
		begin
			if (&sp)
				ovf = 1'b1;
			else
				stk[++sp] = pc + 21'h2;
			pc = c == 3'h2 ? a : c == 3'h4 ? 21'h8 : 21'h18;
		end
		else
			pc += {s, 1'b0};
	endtask

	function automatic logic [31:0] ptr();
		return {&sp, unf, ovf, sp};
	endfunction

	always @(posedge MCLK)
	begin
		if ((RVALID & RREADY) === 1'b1)
			check({RRESP, RDATA}, qr.pop_front());
		if ((BVALID & BREADY) === 1'b1)
			check(34'(BRESP), 34'(qb.pop_front()));
	end

	initial
	begin
		{RST, AWVALID, WVALID, BREADY, ARVALID, RREADY, AWADDR, ARADDR, WDATA} = {6'h20, 48'h0};
		{pc, sp, ovf, unf, mismatches, check_count} = 0;
		void'($urandom(32'hB4C55F41));
		repeat (10)
			@(posedge MCLK);
		RST <= 1'b0;
		rd(8'h0C, 0);
		rd(8'h20, 0, 2'h2);
		wr(8'h24, 0, 2'h2);
		repeat (3)
			op(3'h0, 0, 1);
		lh = 8'($urandom);
		lu = 8'($urandom % 32);
		wr(8'h04, lh);
		wr(8'h08, lu);
		op(3'h1, 21'($urandom) & 21'h1FFFFE, 1);
		op(3'h0);
		rd(8'h1C, pc);
		repeat (32)
			op(3'h2, 21'($urandom) & 21'h1FFFFE);
		op(3'h0);
		rd(8'h0C, ptr());
		rd(8'h04, lh);
		rd(8'h10, stk[sp][20:16]);
		stk[sp][7:0] = 8'h3C;
		wr(8'h18, 8'h3C);
		repeat (32)
		begin
			op(3'h3);
			op(3'h0);
			rd(8'h1C, pc);
		end
		rd(8'h0C, ptr());
		wr(8'h0C, 0);
		{sp, ovf, unf} = 0;
		rd(8'h0C, 0);
		op(3'h4);
		op(3'h5);
		op(3'h0);
		rd(8'h18, stk[sp][7:0]);
		rd(8'h1C, pc);
		op(3'h3);
		op(3'h3);
		op(3'h1, 21'($urandom) & 21'h1FFFFE);
		op(3'h0);
		lh = pc[15:8];
		lu = pc[20:16];
		rd(8'h00, pc[7:0]);
		rd(8'h04, lh);
		rd(8'h08, lu);
		lh = ~lh;
		wr(8'h04, lh);
		wr(8'h00, 8'h5B);
		pc = {lu[4:0], lh, 8'h5A};
		rd(8'h1C, pc);
		rd(8'h00, 8'h5A);
		conclude();
	end
endmodule
